// >>> hdl/ifctl_reg.sv
// Interface control register of the transceiver with its derived controls
// Notes on behaviour
// - Reads of 07h, 08h and 09h all return the register contents.
// - Write at 07h loads, 08h sets ones, 09h clears ones.
// - Protect enabled: weak pull-up on STP, data pull-downs when STP unexpectedly high.
// - Protect enabled: detect link no longer driving STP, then protect data inputs.
// - Protect disabled: remove STP pull-up and data-line pull-downs.
// - Invert bit set inverts the fault input; clear passes it unchanged.
// - Clock power bit keeps clock powered in serial modes when one, else unpowered.
// - Clock power bit honoured only in serial mode with low-power control at one.
// - Three-wire bit one selects 3-bit serial interface, zero the parallel one.
// - Leaving three-wire mode clears the three-wire bit automatically.
// - Six-wire bit one selects the 6-bit serial interface.
// - Leaving six-wire mode clears the six-wire bit automatically.
// - Low-power control zero enters low-power mode, keeping minimal blocks powered.
`timescale 1ns/100ps
`include "ifctl_cfg.svh"

module ifctl_reg
    import ifctl_pkg::*;
#(
    parameter int ADDR_W = 6
)
(
    input  wire logic              core_clk,
    input  wire logic              sys_rst,
    input  wire logic              reg_wr_en,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [7:0]        reg_wr_data,
    input  wire logic              reg_rd_en,
    input  wire logic              three_wire_exit,
    input  wire logic              six_wire_exit,
    input  wire logic              low_power_n,
    input  wire logic              stp_in,
    input  wire logic              stp_driven,
    input  wire logic              fault_in,
    output logic      [7:0]        reg_rd_data,
    output logic                   reg_rd_valid,
    output logic      [7:0]        interface_control,
    output logic                   stp_pullup_en,
    output logic                   data_pulldown_en,
    output logic                   indicator_out,
    output logic                   serial_clock_powered,
    output logic                   three_wire_serial_mode,
    output logic                   six_wire_serial_mode,
    output logic                   low_power_mode
);

    // ==========================================================
    // Address decode
    function automatic ifctl_acc_t decode_acc(input logic [ADDR_W-1:0] addr);
        ifctl_acc_t acc;
        acc = IFCTL_ACC_NONE;
        case (addr)
            `IFCTL_ADDR_WRITE: acc = IFCTL_ACC_WRITE;
            `IFCTL_ADDR_SET:   acc = IFCTL_ACC_SET;
            `IFCTL_ADDR_CLEAR: acc = IFCTL_ACC_CLEAR;
            default:           acc = IFCTL_ACC_NONE;
        endcase
        return acc;
    endfunction

    // Drops the reserved positions so they always read zero
    function automatic logic [7:0] keep_defined(input logic [7:0] value);
        logic [7:0] kept;
        kept = value & ~`IFCTL_RESERVED_MSK;
        return kept;
    endfunction

    // One-hot mask for a single bit position
    function automatic logic [7:0] bit_mask(input logic pulse, input int unsigned pos);
        logic [7:0] mask;
        mask = {7'h00, pulse} << pos;
        return mask;
    endfunction

    // ==========================================================
    // Register bus decode signals
    ifctl_acc_t wr_acc;
    ifctl_acc_t rd_acc;
    logic       rd_hit;

    // ==========================================================
    // Control register and its next value
    logic [7:0] ctrl_q;
    logic [7:0] ctrl_d;
    logic [7:0] load_val;
    logic [7:0] set_val;
    logic [7:0] clear_val;
    logic [7:0] written;
    logic [7:0] auto_clr;

    // ==========================================================
    // Output flops and their next values
    logic [7:0] rd_data_q;
    logic [7:0] rd_data_d;
    logic       rd_valid_q;
    logic       rd_valid_d;
    logic       pullup_q;
    logic       pullup_d;
    logic       pulldown_q;
    logic       pulldown_d;
    logic       indicator_q;
    logic       indicator_d;
    logic       clk_pwr_q;
    logic       clk_pwr_d;
    logic       three_wire_q;
    logic       three_wire_d;
    logic       six_wire_q;
    logic       six_wire_d;
    logic       low_power_q;
    logic       low_power_d;
    logic       prot_on;
    logic       serial_on;
    logic       stp_floating;

    // ==========================================================
    // Access decode
    assign wr_acc = reg_wr_en ? decode_acc(reg_addr) : IFCTL_ACC_NONE;
    assign rd_acc = reg_rd_en ? decode_acc(reg_addr) : IFCTL_ACC_NONE;
    assign rd_hit = (rd_acc != IFCTL_ACC_NONE);

    // ==========================================================
    // Register update
    assign load_val  = reg_wr_data;
    assign set_val   = ctrl_q | reg_wr_data;
    assign clear_val = ctrl_q & ~reg_wr_data;
    assign written   = (wr_acc == IFCTL_ACC_WRITE) ? load_val
                     : (wr_acc == IFCTL_ACC_SET)   ? set_val
                     : (wr_acc == IFCTL_ACC_CLEAR) ? clear_val
                     : ctrl_q;

    // Leaving a serial mode clears its bit, winning over a same-cycle write
    assign auto_clr = bit_mask(three_wire_exit, `IFCTL_BIT_THREE_W)
                    | bit_mask(six_wire_exit, `IFCTL_BIT_SIX_W);
    assign ctrl_d   = keep_defined(written & ~auto_clr);

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            ctrl_q <= `IFCTL_RESET_VALUE;
        end
        else
        begin
            ctrl_q <= ctrl_d;
        end
    end

    // ==========================================================
    // Read port
    // Unmapped reads answer with valid low and idle data
    assign rd_valid_d = rd_hit;
    assign rd_data_d  = rd_hit ? ctrl_q : `IFCTL_RD_IDLE;

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            rd_valid_q <= `IFCTL_FLAG_RESET;
        end
        else
        begin
            rd_valid_q <= rd_valid_d;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            rd_data_q <= `IFCTL_RD_IDLE;
        end
        else
        begin
            rd_data_q <= rd_data_d;
        end
    end

    // ==========================================================
    // Interface protection
    // Pull-downs also cover a released STP, which the pull-up lifts
    assign prot_on      = ~ctrl_d[`IFCTL_BIT_PROT_DIS];
    assign stp_floating = ~stp_driven | stp_in;
    assign pullup_d     = prot_on;
    assign pulldown_d   = prot_on & stp_floating;

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            pullup_q <= `IFCTL_PULLUP_RESET;
        end
        else
        begin
            pullup_q <= pullup_d;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            pulldown_q <= `IFCTL_FLAG_RESET;
        end
        else
        begin
            pulldown_q <= pulldown_d;
        end
    end

    // ==========================================================
    // Fault indicator
    assign indicator_d = fault_in ^ ctrl_d[`IFCTL_BIT_INVERT];

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            indicator_q <= `IFCTL_FLAG_RESET;
        end
        else
        begin
            indicator_q <= indicator_d;
        end
    end

    // ==========================================================
    // Serial modes and clock power
    assign serial_on    = ctrl_d[`IFCTL_BIT_THREE_W] | ctrl_d[`IFCTL_BIT_SIX_W];
    assign clk_pwr_d    = serial_on & low_power_n & ctrl_d[`IFCTL_BIT_CLK_PWR];
    assign three_wire_d = ctrl_d[`IFCTL_BIT_THREE_W];
    assign six_wire_d   = ctrl_d[`IFCTL_BIT_SIX_W];

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            clk_pwr_q <= `IFCTL_FLAG_RESET;
        end
        else
        begin
            clk_pwr_q <= clk_pwr_d;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            three_wire_q <= `IFCTL_FLAG_RESET;
        end
        else
        begin
            three_wire_q <= three_wire_d;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            six_wire_q <= `IFCTL_FLAG_RESET;
        end
        else
        begin
            six_wire_q <= six_wire_d;
        end
    end

    // ==========================================================
    // Low-power control
    assign low_power_d = ~low_power_n;

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            low_power_q <= `IFCTL_FLAG_RESET;
        end
        else
        begin
            low_power_q <= low_power_d;
        end
    end

    // ==========================================================
    // Outputs
    assign reg_rd_data            = rd_data_q;
    assign reg_rd_valid           = rd_valid_q;
    assign interface_control      = ctrl_q;
    assign stp_pullup_en          = pullup_q;
    assign data_pulldown_en       = pulldown_q;
    assign indicator_out          = indicator_q;
    assign serial_clock_powered   = clk_pwr_q;
    assign three_wire_serial_mode = three_wire_q;
    assign six_wire_serial_mode   = six_wire_q;
    assign low_power_mode         = low_power_q;

endmodule

// >>> inc/ifctl_cfg.svh
// Offsets, field positions and reset values of the interface control register
`ifndef IFCTL_CFG_SVH
`define IFCTL_CFG_SVH

`define IFCTL_ADDR_WRITE   6'h07
`define IFCTL_ADDR_SET     6'h08
`define IFCTL_ADDR_CLEAR   6'h09
`define IFCTL_RESET_VALUE  8'h00
`define IFCTL_RESERVED_MSK 8'h14
`define IFCTL_RD_IDLE      8'h00
`define IFCTL_FLAG_RESET   1'h0
`define IFCTL_PULLUP_RESET 1'h1

`define IFCTL_BIT_PROT_DIS 7
`define IFCTL_BIT_PASSTHRU 6
`define IFCTL_BIT_INVERT   5
`define IFCTL_BIT_CLK_PWR  3
`define IFCTL_BIT_THREE_W  1
`define IFCTL_BIT_SIX_W    0

`endif

// >>> inc/ifctl_pkg.sv
// Types shared by the interface control register block
package ifctl_pkg;

    typedef enum logic [1:0]
    {
        IFCTL_ACC_WRITE = 2'b00,
        IFCTL_ACC_SET   = 2'b01,
        IFCTL_ACC_CLEAR = 2'b10,
        IFCTL_ACC_NONE  = 2'b11
    } ifctl_acc_t;

endpackage

// >>> verif/ifctl_link_model.sv
// Link-side model of the STP pin
`timescale 1ns/100ps
module ifctl_link_model (
    input  wire logic core_clk, release_stp, stp_level, stp_pullup_en,
    output logic      stp_driven, stp_in
);
    logic toggle_q = 1'b0;
    always_ff @(posedge core_clk) toggle_q <= !toggle_q;
    assign stp_driven = !release_stp;
    // Released pin floats to the pull-up, else wanders
    assign stp_in = stp_driven ? stp_level : (stp_pullup_en ? 1'b1 : toggle_q);
endmodule

// >>> verif/ifctl_reg_checker.sv
// Port assertions for the interface control register
`timescale 1ns/100ps
module ifctl_reg_checker (
    input wire logic       core_clk, sys_rst, reg_wr_en, reg_rd_en, three_wire_exit, low_power_n, reg_rd_valid,
    input wire logic       stp_pullup_en, serial_clock_powered, three_wire_serial_mode, low_power_mode,
    input wire logic       six_wire_exit, six_wire_serial_mode, stp_in, stp_driven, fault_in, data_pulldown_en,
    input wire logic       indicator_out,
    input wire logic [5:0] reg_addr,
    input wire logic [7:0] reg_wr_data, reg_rd_data, interface_control
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    wire logic hit = reg_addr inside {6'h07, 6'h08, 6'h09};
    rd_data_a: assert property (reg_rd_en && hit |=> reg_rd_valid && reg_rd_data == $past(interface_control))
        else $error("read data wrong");
    rd_unmapped_a: assert property (reg_rd_en && !hit |=> !reg_rd_valid) else $error("unmapped read");
    wr_load_a: assert property (reg_wr_en && reg_addr == 6'h07 |=>
        interface_control[7:2] == ($past(reg_wr_data[7:2]) & 6'h3a)) else $error("load wrong");
    wr_set_a: assert property (reg_wr_en && reg_addr == 6'h08 |=> interface_control[7:2] ==
        (($past(interface_control[7:2]) | $past(reg_wr_data[7:2])) & 6'h3a)) else $error("set wrong");
    wr_clear_a: assert property (reg_wr_en && reg_addr == 6'h09 |=> interface_control[7:2] ==
        ($past(interface_control[7:2]) & ~$past(reg_wr_data[7:2]))) else $error("clear wrong");
    exit_clear_a: assert property (three_wire_exit |=> !interface_control[1] && !three_wire_serial_mode)
        else $error("mode bit kept");
    stp_pullup_a: assert property (stp_pullup_en != interface_control[7]) else $error("pull-up wrong");
    exit_six_a: assert property (six_wire_exit |=> !interface_control[0] && !six_wire_serial_mode)
        else $error("six-wire bit kept");
    mode_bits_a: assert property (three_wire_serial_mode == interface_control[1]
        && six_wire_serial_mode == interface_control[0]) else $error("mode output wrong");
    pulldown_a: assert property (!$past(sys_rst) |-> data_pulldown_en ==
        (!interface_control[7] && (!$past(stp_driven) || $past(stp_in)))) else $error("pull-down wrong");
    indicator_a: assert property (!$past(sys_rst) |-> indicator_out ==
        ($past(fault_in) ^ interface_control[5])) else $error("indicator wrong");
    clk_power_a: assert property (!$past(sys_rst) && $stable(interface_control) && $stable(low_power_n) |->
        serial_clock_powered == (|interface_control[1:0] && low_power_n && interface_control[3]))
        else $error("clock power wrong");
    low_power_a: assert property (!$past(sys_rst) |-> low_power_mode == !$past(low_power_n))
        else $error("low power wrong");
endmodule
bind ifctl_reg ifctl_reg_checker u_chk (.*);

// >>> verif/tb_top.sv
// Self-checking bench for the interface control register
`timescale 1ns/100ps
module tb_top;
    logic        core_clk = 1'b0, sys_rst = 1'b1, reg_wr_en = 1'b0, reg_rd_en = 1'b0, three_wire_exit = 1'b0;
    logic        six_wire_exit = 1'b0, low_power_n = 1'b1, fault_in = 1'b0, release_stp = 1'b0, stp_level = 1'b0;
    logic        reg_rd_valid, stp_pullup_en, data_pulldown_en, indicator_out, serial_clock_powered, stp_in;
    logic        stp_driven, three_wire_serial_mode, six_wire_serial_mode, low_power_mode;
    logic [5:0]  reg_addr = 6'h00, a;
    logic [7:0]  reg_wr_data = 8'h00, reg_rd_data, interface_control, m = 8'h00, d, e;
    logic [31:0] seed = 32'h0000_580a, r;
    logic [7:0]  q[$];
    int          miscompares = 0, num_checks = 0;
    ifctl_reg dut (.*);
    ifctl_link_model link (.*);
    initial forever #5 core_clk = !core_clk;
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic end_of_test();
        if (miscompares == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    always @(posedge core_clk)
    begin
        #1;
        if (reg_rd_valid === 1'b1)
        begin
            e = q.size() ? q.pop_front() : 8'hxx;
            num_checks++;
            if (reg_rd_data !== e)
            begin
                $display("mismatch at %0t: %h expected %h", $time, reg_rd_data, e);
                miscompares++;
            end
        end
    end
    initial
    begin
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 400; i++)
        begin
            r = xs();
            d = r[7:0];
            a = (r[13:12] == 2'b11) ? 6'h0a : 6'h07 + r[13:12];
            d[6] = (a != 6'h09);
            if ((((a == 6'h08) ? m[1:0] : 2'b00) | d[1:0]) == 2'b11)
                d[1:0] = 2'b00;
            if (!r[14] && a != 6'h0a)
                q.push_back(m);
            else if (r[14] && a == 6'h07)
                m = d & 8'heb;
            else if (r[14] && a == 6'h08)
                m = (m | d) & 8'heb;
            else if (r[14] && a == 6'h09)
                m = m & ~d;
            m[1:0] = m[1:0] & ~{&r[17:16], &r[19:18]};
            reg_addr <= a;
            reg_wr_data <= d;
            reg_wr_en <= r[14];
            reg_rd_en <= !r[14];
            three_wire_exit <= &r[17:16];
            six_wire_exit <= &r[19:18];
            low_power_n <= r[20] | r[21];
            fault_in <= r[22];
            release_stp <= r[23];
            stp_level <= r[24];
            @(posedge core_clk);
        end
        reg_rd_en <= 1'b0;
        reg_wr_en <= 1'b0;
        repeat (3) @(posedge core_clk);
        if (q.size() != 0)
        begin
            $display("mismatch at %0t: %h expected %h", $time, q.size(), 0);
            miscompares++;
        end
        end_of_test();
    end
    initial
    begin
        #10000;
        miscompares++;
        end_of_test();
    end
endmodule
